// ==== hw/charge_timer_thermistor_ctrl.sv ====
`timescale 1ns/1ps
// How it works
// - thermistor monitor enable bit, read/write, resets to one.
// - read-only fault code: 00 normal, 01 suspend, 10 cool halves current.
// - warm region reports 11 and lowers regulation voltage by 140 mV.
// - half-current bit, reset zero, halves programmed charge current when set.
// - stretch enable with active condition advances safety timer at half rate.
// - current limit, voltage limit, thermal, half bit, short, cool each stretch.
// - stretch enable zero keeps timer at normal rate always.
// - two-bit limit selects 27 min, 6 h, 9 h or off, default 00.
module charge_timer_thermistor_ctrl #(
	parameter longint tick_count = chg_timer_pkg::tick_cycles
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// register port
	input wire logic reg_wr,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	// analog status, asynchronous
	input wire chg_timer_pkg::temp_cmp_s temp_cmp,
	input wire chg_timer_pkg::limit_cond_s limit_cond,
	input wire logic charging,
	// controls to the power stage
	output logic charge_suspend,
	output logic half_current,
	output logic [7:0] vreg_drop_mv,
	output logic timer_expired
);
	import chg_timer_pkg::*;

	// control register fields
	logic timer_stretch_enable;
	logic [1:0] timer_limit;
	logic spare;
	logic thermistor_monitor_enable;
	logic half_current_select;
	logic [1:0] temp_fault_code;

	// synchroniser stages and the accepted levels
	logic [2:0] tsync [4];
	logic [2:0] lsync [5];
	logic [3:0] tcmp;
	logic [4:0] lcond;

	// safety timer state
	logic [31:0] tick_cnt;
	logic [15:0] sec_cnt;
	logic half_phase;

	// raw asynchronous levels; charging sits above the four limit conditions
	wire logic [3:0] tcmp_raw = temp_cmp;
	wire logic [4:0] cond_raw = {charging, limit_cond};

	// fault code from comparator bits 3 below_cold, 2 below_cool, 1 above_warm, 0 above_hot
	function automatic logic [1:0] fault_of(input logic enable, input logic [3:0] cmp);
		logic suspend_zone;
		logic cool_zone;
		logic warm_zone;
		suspend_zone = cmp[3] | cmp[0];
		cool_zone = cmp[2] & ~cmp[3];
		warm_zone = cmp[1] & ~cmp[0];
		if (!enable)
			return fault_none;
		else if (suspend_zone)
			return fault_suspend;
		else if (cool_zone)
			return fault_cool;
		else if (warm_zone)
			return fault_warm;
		else
			return fault_none;
	endfunction

	// seconds allowed by a timer limit code; the off code holds the timer cleared instead
	function automatic logic [15:0] limit_of(input logic [1:0] code);
		case (code)
			limit_27min: return 16'(secs_27min);
			limit_6h: return 16'(secs_6h);
			limit_9h: return 16'(secs_9h);
			default: return 16'(secs_9h);
		endcase
	endfunction

	// three-stage synchronisers; a change is accepted when stages two and three agree
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_ts
			always_ff @(posedge core_clk) begin
				tsync[g] <= {tsync[g][1:0], tcmp_raw[g]};
			end
			always_ff @(posedge core_clk) begin
				if (rst)
					tcmp[g] <= 1'b0;
				else if (tsync[g][1] == tsync[g][2])
					tcmp[g] <= tsync[g][2];
			end
		end
		for (g = 0; g < 5; g++) begin : g_ls
			always_ff @(posedge core_clk) begin
				lsync[g] <= {lsync[g][1:0], cond_raw[g]};
			end
			always_ff @(posedge core_clk) begin
				if (rst)
					lcond[g] <= 1'b0;
				else if (lsync[g][1] == lsync[g][2])
					lcond[g] <= lsync[g][2];
			end
		end
	endgenerate

	// fault code for the next edge and the power-stage requests it makes
	wire logic [1:0] next_fault = fault_of(thermistor_monitor_enable, tcmp);
	wire logic next_suspend = (next_fault == fault_suspend);
	wire logic next_cool = (next_fault == fault_cool);
	wire logic next_warm = (next_fault == fault_warm);
	wire logic next_half = half_current_select | next_cool;
	wire logic [7:0] next_drop = next_warm ? reg_drop_code : 8'h00;

	// register decode; the read image carries the live fault code
	wire logic addr_hit = (reg_addr == ctl_reg_addr);
	wire logic wr_hit = reg_wr && addr_hit;
	wire logic [7:0] reg_image = {timer_stretch_enable, timer_limit, spare,
		thermistor_monitor_enable, temp_fault_code, half_current_select};

	// conditions that stretch the safety timer
	wire logic rate_limited = |lcond[3:0];
	wire logic cool_region = (temp_fault_code == fault_cool);
	wire logic stretch_cond = rate_limited | half_current_select | cool_region;
	wire logic slow = timer_stretch_enable & stretch_cond;

	// timer control: held cleared while not charging or with the timers off
	wire logic charging_now = lcond[4];
	wire logic timers_on = (timer_limit != limit_off);
	wire logic timer_hold = rst || !charging_now || !timers_on;
	wire logic tick = (tick_cnt == 32'(tick_count - 1));
	wire logic [15:0] limit_secs = limit_of(timer_limit);
	wire logic at_limit = (sec_cnt == limit_secs);
	wire logic count_sec = tick && (!slow || half_phase) && !at_limit;

	// timer stretch enable
	always_ff @(posedge core_clk) begin
		if (rst)
			timer_stretch_enable <= rst_stretch;
		else if (wr_hit)
			timer_stretch_enable <= reg_wdata[stretch_bit];
	end

	// timer limit
	always_ff @(posedge core_clk) begin
		if (rst)
			timer_limit <= rst_limit;
		else if (wr_hit)
			timer_limit <= reg_wdata[limit_hi_bit:limit_lo_bit];
	end

	// spare bit, stored and read back only
	always_ff @(posedge core_clk) begin
		if (rst)
			spare <= rst_spare;
		else if (wr_hit)
			spare <= reg_wdata[spare_bit];
	end

	// thermistor monitor enable
	always_ff @(posedge core_clk) begin
		if (rst)
			thermistor_monitor_enable <= rst_monitor;
		else if (wr_hit)
			thermistor_monitor_enable <= reg_wdata[monitor_bit];
	end

	// half-current select; the fault bits of the write data go nowhere
	always_ff @(posedge core_clk) begin
		if (rst)
			half_current_select <= rst_half;
		else if (wr_hit)
			half_current_select <= reg_wdata[half_bit];
	end

	// fault code, driven only by the comparators and the monitor enable
	always_ff @(posedge core_clk) begin
		if (rst)
			temp_fault_code <= fault_none;
		else
			temp_fault_code <= next_fault;
	end

	// charge suspend
	always_ff @(posedge core_clk) begin
		if (rst)
			charge_suspend <= 1'b0;
		else
			charge_suspend <= next_suspend;
	end

	// half current
	always_ff @(posedge core_clk) begin
		if (rst)
			half_current <= 1'b0;
		else
			half_current <= next_half;
	end

	// regulation voltage drop
	always_ff @(posedge core_clk) begin
		if (rst)
			vreg_drop_mv <= 8'h00;
		else
			vreg_drop_mv <= next_drop;
	end

	// timer prescaler, one tick per timer second
	always_ff @(posedge core_clk) begin
		if (timer_hold)
			tick_cnt <= '0;
		else
			tick_cnt <= tick ? '0 : tick_cnt + 32'd1;
	end

	// every other tick is skipped while slowed
	always_ff @(posedge core_clk) begin
		if (timer_hold)
			half_phase <= 1'b0;
		else if (tick)
			half_phase <= slow ? ~half_phase : 1'b0;
	end

	// elapsed seconds, saturating at the limit
	always_ff @(posedge core_clk) begin
		if (timer_hold)
			sec_cnt <= '0;
		else if (count_sec)
			sec_cnt <= sec_cnt + 16'd1;
	end

	// expiry flag
	always_ff @(posedge core_clk) begin
		if (timer_hold)
			timer_expired <= 1'b0;
		else
			timer_expired <= at_limit;
	end

	// read data register, zero for unmapped addresses
	always_ff @(posedge core_clk) begin
		if (rst)
			reg_rdata <= 8'h00;
		else if (addr_hit)
			reg_rdata <= reg_image;
		else
			reg_rdata <= 8'h00;
	end
endmodule

// ==== hw/chg_timer_pkg.sv ====
package chg_timer_pkg;
	// register address and field positions
	localparam logic [7:0] ctl_reg_addr = 8'h07;
	localparam int stretch_bit = 7;
	localparam int limit_hi_bit = 6;
	localparam int limit_lo_bit = 5;
	localparam int spare_bit = 4;
	localparam int monitor_bit = 3;
	localparam int fault_hi_bit = 2;
	localparam int fault_lo_bit = 1;
	localparam int half_bit = 0;
	// reset values of the writable fields
	localparam logic rst_stretch = 1'b0;
	localparam logic [1:0] rst_limit = 2'b00;
	localparam logic rst_spare = 1'b1;
	localparam logic rst_monitor = 1'b1;
	localparam logic rst_half = 1'b0;
	// fault codes
	localparam logic [1:0] fault_none = 2'b00;
	localparam logic [1:0] fault_suspend = 2'b01;
	localparam logic [1:0] fault_cool = 2'b10;
	localparam logic [1:0] fault_warm = 2'b11;
	// safety timer limits
	localparam logic [1:0] limit_27min = 2'b00;
	localparam logic [1:0] limit_6h = 2'b01;
	localparam logic [1:0] limit_9h = 2'b10;
	localparam logic [1:0] limit_off = 2'b11;
	localparam int reg_drop_mv = 140;
	localparam logic [7:0] reg_drop_code = 8'(reg_drop_mv);
	// timing: one timer tick per second
	localparam longint clk_hz = 100000000;
	localparam int tick_s = 1;
	localparam longint tick_cycles = clk_hz * tick_s;
	localparam int secs_27min = 27 * 60;
	localparam int secs_6h = 6 * 3600;
	localparam int secs_9h = 9 * 3600;

	// temperature comparator results
	typedef struct packed {
		logic below_cold;
		logic below_cool;
		logic above_warm;
		logic above_hot;
	} temp_cmp_s;

	// conditions that slow the timer
	typedef struct packed {
		logic input_current_limit;
		logic input_voltage_power_limit;
		logic thermal_regulation;
		logic battery_short_condition;
	} limit_cond_s;
endpackage

// ==== verif/charge_timer_thermistor_ctrl_test.sv ====
`timescale 1ns/1ps
`define chk(a, b) begin checks++; if ((a) !== (b)) begin mismatches++; $display("unexpected %0t %h %h", $time, a, b); end end
module charge_timer_thermistor_ctrl_test;
	import chg_timer_pkg::*;
	localparam int tk = 4;
	localparam int t1 = secs_27min * tk / 1000;
	logic core_clk = 0, rst = 1, charging = 0, reg_wr, charge_suspend, half_current, timer_expired;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, vreg_drop_mv, d;
	temp_cmp_s temp_cmp = '0;
	limit_cond_s limit_cond = '0;
	int checks = 0, mismatches = 0, n;
	logic [5:0] tbl [5] = '{6'h31, 6'h12, 6'h0b, 6'h0d, 6'h30};
	host_model h(.*);
	charge_timer_thermistor_ctrl #(.tick_count(tk)) DUT(.*);
	// clock and watchdog
	initial forever #5 core_clk = ~core_clk;
	initial begin
		#1000000;
		mismatches++;
		results;
	end
	task results;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task t_regs;
		h.rd(ctl_reg_addr, d);
		`chk(d[6:0], 7'h18)
		h.rd(8'h05, d);
		`chk(d, 8'h00)
		h.wr(ctl_reg_addr, 8'h7f);
		h.rd(ctl_reg_addr, d);
		`chk(d[6:0], 7'h79)
		`chk(half_current, 1'h1)
		$display("regs done");
	endtask
	// comparator patterns; last one with monitoring off
	task t_faults;
		h.wr(ctl_reg_addr, 8'h18);
		for (int i = 0; i < 5; i++) begin
			if (i == 4) h.wr(ctl_reg_addr, 8'h10);
			temp_cmp = tbl[i][5:2];
			repeat (8) @(posedge core_clk);
			h.rd(ctl_reg_addr, d);
			`chk(d[2:1], tbl[i][1:0])
			`chk({charge_suspend, half_current}, {tbl[i][1:0] == fault_suspend, tbl[i][1:0] == fault_cool})
			`chk(vreg_drop_mv, tbl[i][1:0] == fault_warm ? reg_drop_code : 8'h00)
		end
		$display("faults done");
	endtask
	// runs the timer to expiry, compared in thousands of cycles
	task tmr(input logic [7:0] v, input int k);
		h.wr(ctl_reg_addr, v);
		charging = 0;
		repeat (8) @(posedge core_clk);
		#1 charging = 1;
		for (n = 0; timer_expired !== 1'h1 && n < 30000; n++) @(posedge core_clk) #1;
		`chk(n / 1000, k)
	endtask
	task t_timer;
		temp_cmp = '0;
		limit_cond = 4'h2;
		tmr(8'h18, t1);
		tmr(8'h98, 2 * t1);
		#1 limit_cond = '0;
		tmr(8'h99, 2 * t1);
		tmr(8'h78, 30);
		$display("timer done");
	endtask
	initial begin
		repeat (12) @(posedge core_clk);
		#1 rst = 0;
		t_regs;
		t_faults;
		t_timer;
		results;
	end
endmodule

// ==== verif/ctl_sva.sv ====
`timescale 1ns/1ps
module ctl_sva
	import chg_timer_pkg::*;
(
	// watched ports
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_rdata,
	input wire logic charge_suspend,
	input wire logic half_current,
	input wire logic [7:0] vreg_drop_mv
);
	logic was_rst;
	logic hit;
	wire logic [1:0] code = reg_rdata[2:1];
	// reset seen last edge, and read data now shows the control register
	always_ff @(posedge core_clk) begin
		was_rst <= rst;
		hit <= reg_addr == ctl_reg_addr;
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	AST_RST: assert property (was_rst && reg_addr == ctl_reg_addr |=> reg_rdata[6:0] == 7'h18) else $error("reset");
	AST_SUSP: assert property (hit && code == fault_suspend |-> $past(charge_suspend)) else $error("suspend");
	AST_NOSUSP: assert property (hit && code != fault_suspend |-> !$past(charge_suspend)) else $error("nosusp");
	AST_COOL: assert property (hit && code == fault_cool |-> $past(half_current)) else $error("cool");
	AST_WARM: assert property (hit && code == fault_warm |-> $past(vreg_drop_mv) == reg_drop_code) else $error("warm");
	AST_DROP: assert property (vreg_drop_mv != 8'h00 |-> vreg_drop_mv == reg_drop_code) else $error("drop");
	AST_HALF: assert property (hit && reg_rdata[half_bit] |-> ##[0:1] half_current) else $error("half");
	AST_NONE: assert property (hit && !reg_rdata[half_bit] ##1 hit && code != fault_cool |-> !$past(half_current))
		else $error("none");
endmodule
bind charge_timer_thermistor_ctrl ctl_sva u_sva(.*);

// ==== verif/host_model.sv ====
`timescale 1ns/1ps
module host_model (
	// register port
	input wire logic core_clk,
	output logic reg_wr = 1'h0,
	output logic [7:0] reg_addr = 8'h07,
	output logic [7:0] reg_wdata = 8'h00,
	input wire logic [7:0] reg_rdata
);
	// one strobe cycle, data scrambled afterwards
	task wr(input logic [7:0] a, v);
		@(posedge core_clk);
		#1 reg_wr = 1'h1;
		reg_addr = a;
		reg_wdata = v;
		@(posedge core_clk);
		#1 reg_wr = 1'h0;
		reg_wdata = ~v;
	endtask
	// read data is registered one cycle after the address
	task rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge core_clk);
		#1 reg_addr = a;
		repeat (2) @(posedge core_clk);
		#1 v = reg_rdata;
	endtask
endmodule
